/* File: logic/fesc_pkg.sv */
package fesc_pkg;
    // ==========================================================
    // software register map (byte addresses, one word each)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    // CTRL fields
    localparam int CTRL_PD_BIT = 0;
    localparam int CTRL_UNLOCK_BIT = 1;
    localparam int CTRL_VPP_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    // STAT fields
    localparam int STAT_DATA_LSB = 8;
    localparam int STAT_BUSY_BIT = 16;
    localparam int STAT_DONE_BIT = 17;
    localparam int STAT_REFUSED_BIT = 18;
    localparam int STAT_SUSP_BIT = 19;
    // ==========================================================
    // device status byte
    localparam int SR_READY_BIT = 7;
    localparam int SR_SUSP_BIT = 6;
    // ==========================================================
    // flash command bytes
    localparam logic [7:0] CMD_ERASE_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_ERASE_RESUME = 8'hD0;
    // ==========================================================
    // software operations written to CMD[2:0]
    typedef enum logic [2:0] {
        FESC_OP_NONE = 3'h0,
        FESC_OP_ERASE = 3'h1,
        FESC_OP_SUSPEND = 3'h2,
        FESC_OP_RESUME = 3'h3,
        FESC_OP_CLEAR = 3'h4,
        FESC_OP_RD_ARRAY = 3'h5,
        FESC_OP_RD_STATUS = 3'h6,
        FESC_OP_READ = 3'h7
    } fesc_op_e;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int RECOVERY_NS = 300;
    localparam int RECOVERY_CYC =
        (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;
    localparam int ADDR_W = 18;
endpackage

/* File: logic/fesc_ctrl.sv */
// Contract
// - erase: setup write, then confirm at block
// - read array command before array reads; FESC_OP_READ reads without one
// - suspend, then read status to confirm
// - assert chip select, then write resume
// - reset low deselects; wait recovery before read
// - write only with strobe and select low
`timescale 1ns/1ps
module fesc_ctrl #(
    parameter int WE_CYC = 2,
    parameter int ACC_CYC = 3,
    parameter logic [7:0] CMD_ERASE_SETUP = 8'h20,
    parameter logic [7:0] CMD_CLEAR_STATUS = 8'h50,
    parameter logic [7:0] CMD_READ_STATUS = 8'h70,
    parameter logic [7:0] CMD_READ_ARRAY = 8'hFF
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic [fesc_pkg::ADDR_W-1:0] addr_o,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic dq_oe_o,
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic reset_powerdown_n_o,
    output logic unlock_high_voltage_o,
    output logic vpp_en_o
);
    import fesc_pkg::*;

    if (WE_CYC < 1 || WE_CYC > 200 || ACC_CYC < 1 || ACC_CYC > 200) begin
        $error("fesc_ctrl: strobe or access count out of range");
    end

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_WSET = 6'b000010,
        S_WPUL = 6'b000100,
        S_WREC = 6'b001000,
        S_RACC = 6'b010000,
        S_RSMP = 6'b100000
    } fesc_state_e;

    // ==========================================================
    // registers
    fesc_state_e state_reg, state_next;
    logic [2:0] ctrl_reg;
    logic [ADDR_W-1:0] blk_addr_reg;
    fesc_op_e op_reg;
    logic [1:0] wr_left_reg;
    logic [7:0] byte0_reg, byte1_reg, last_byte_reg;
    logic rd_need_reg, poll_reg;
    logic [7:0] cnt_reg;
    logic [7:0] sr_reg, data_reg;
    logic done_reg, refused_reg, susp_reg;
    logic [3:0] recov_reg;
    logic [7:0] dq_s1_reg, dq_s2_reg;
    logic [31:0] prdata_reg;

    // ==========================================================
    // register bus decode
    wire logic setup_ph = psel_i && !penable_i;
    wire logic wr_acc = psel_i && penable_i && pwrite_i;
    wire logic hit_ctrl = paddr_i == OFS_CTRL;
    wire logic hit_cmd = paddr_i == OFS_CMD;
    wire logic hit_addr = paddr_i == OFS_ADDR;
    wire logic hit_stat = paddr_i == OFS_STAT;
    wire logic mapped = hit_ctrl || hit_cmd || hit_addr || hit_stat;
    wire fesc_op_e new_op = fesc_op_e'(pwdata_i[2:0]);
    wire logic pd_on = ctrl_reg[CTRL_PD_BIT];
    wire logic busy = state_reg != S_IDLE;
    wire logic cmd_wr = wr_acc && hit_cmd && new_op != FESC_OP_NONE;
    // suspended: only read array, read, resume and status are offered
    wire logic susp_block = susp_reg && (new_op == FESC_OP_ERASE ||
        new_op == FESC_OP_CLEAR || new_op == FESC_OP_SUSPEND);
    wire logic resume_block = !susp_reg && new_op == FESC_OP_RESUME;
    wire logic refuse = cmd_wr && (busy || pd_on || recov_reg != 4'h0 ||
        susp_block || resume_block);
    wire logic start = cmd_wr && !refuse;
    wire logic [31:0] rd_mux =
        hit_ctrl ? {29'h0, ctrl_reg} :
        hit_addr ? {14'h0, blk_addr_reg} :
        hit_stat ? {12'h0, susp_reg, refused_reg, done_reg, busy,
                    data_reg, sr_reg} : 32'h0;

    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o = prdata_reg;

    // ==========================================================
    // operation decode
    wire logic [1:0] op_writes =
        (new_op == FESC_OP_ERASE) ? 2'd2 :
        (new_op == FESC_OP_READ) ? 2'd0 : 2'd1;
    wire logic [7:0] op_byte0 =
        (new_op == FESC_OP_ERASE) ? CMD_ERASE_SETUP :
        (new_op == FESC_OP_SUSPEND) ? CMD_ERASE_SUSPEND :
        (new_op == FESC_OP_RESUME) ? CMD_ERASE_RESUME :
        (new_op == FESC_OP_CLEAR) ? CMD_CLEAR_STATUS :
        (new_op == FESC_OP_RD_ARRAY) ? CMD_READ_ARRAY : CMD_READ_STATUS;
    wire logic op_reads = new_op == FESC_OP_SUSPEND ||
        new_op == FESC_OP_RD_ARRAY || new_op == FESC_OP_RD_STATUS ||
        new_op == FESC_OP_READ;
    wire logic op_polls = new_op == FESC_OP_SUSPEND;
    wire logic cnt_zero = cnt_reg == 8'h0;
    wire logic wr_more = wr_left_reg != 2'd0;
    wire logic poll_again = poll_reg && !dq_s2_reg[SR_READY_BIT];

    // ==========================================================
    // bus cycle engine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (start) begin
                    state_next = (op_writes != 2'd0) ? S_WSET : S_RACC;
                end
            end
            S_WSET: state_next = S_WPUL;
            S_WPUL: begin
                if (cnt_zero) begin
                    state_next = S_WREC;
                end
            end
            S_WREC: begin
                if (wr_more) begin
                    state_next = S_WSET;
                end else if (rd_need_reg) begin
                    state_next = S_RACC;
                end else begin
                    state_next = S_IDLE;
                end
            end
            S_RACC: begin
                if (cnt_zero) begin
                    state_next = S_RSMP;
                end
            end
            S_RSMP: state_next = poll_again ? S_RACC : S_IDLE;
            default: state_next = S_IDLE;
        endcase
        if (pd_on) begin
            state_next = S_IDLE;
        end
    end

    // select low only in a bus cycle; write strobe inside select
    wire logic ce_next = !(state_next == S_WSET || state_next == S_WPUL ||
        state_next == S_RACC);
    wire logic we_next = state_next != S_WPUL;
    wire logic oe_next = state_next != S_RACC;
    wire logic drive_next = state_next == S_WSET || state_next == S_WPUL;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= S_IDLE;
            ce_n_o <= 1'b1;
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            dq_oe_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            ce_n_o <= ce_next;
            we_n_o <= we_next;
            oe_n_o <= oe_next;
            dq_oe_o <= drive_next;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= 8'h0;
        end else if (state_next == S_WPUL && state_reg != S_WPUL) begin
            cnt_reg <= 8'(WE_CYC - 1);
        end else if (state_next == S_RACC && state_reg != S_RACC) begin
            cnt_reg <= 8'(ACC_CYC + SYNC_STAGES - 1);
        end else if (!cnt_zero) begin
            cnt_reg <= cnt_reg - 8'h1;
        end
    end

    // ==========================================================
    // operation bookkeeping
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            op_reg <= FESC_OP_NONE;
            wr_left_reg <= 2'd0;
            byte0_reg <= 8'h0;
            byte1_reg <= 8'h0;
            rd_need_reg <= 1'b0;
            poll_reg <= 1'b0;
        end else if (start) begin
            op_reg <= new_op;
            wr_left_reg <= op_writes;
            byte0_reg <= op_byte0;
            byte1_reg <= CMD_ERASE_CONFIRM;
            rd_need_reg <= op_reads;
            poll_reg <= op_polls;
        end else if (state_reg == S_WPUL && cnt_zero) begin
            wr_left_reg <= wr_left_reg - 2'd1;
            byte0_reg <= byte1_reg;
        end
    end

    // byte0_reg loads on start, so the first byte comes from the decode
    wire logic [7:0] wr_byte = start ? op_byte0 : byte0_reg;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dq_o <= 8'h0;
            addr_o <= '0;
            last_byte_reg <= 8'h0;
        end else begin
            if (state_next == S_WSET) begin
                dq_o <= wr_byte;
                addr_o <= blk_addr_reg;
            end else if (state_next == S_RACC) begin
                addr_o <= blk_addr_reg;
            end
            if (state_reg == S_WREC) begin
                last_byte_reg <= dq_o;
            end
        end
    end

    // pin data passes two flops before use
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dq_s1_reg <= 8'h0;
            dq_s2_reg <= 8'h0;
        end else begin
            dq_s1_reg <= dq_i;
            dq_s2_reg <= dq_s1_reg;
        end
    end

    wire logic is_status = op_reg != FESC_OP_RD_ARRAY &&
        op_reg != FESC_OP_READ;
    wire logic fin = busy && state_next == S_IDLE && !pd_on;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sr_reg <= 8'h0;
            data_reg <= 8'h0;
        end else if (state_reg == S_RSMP) begin
            data_reg <= dq_s2_reg;
            if (is_status) begin
                sr_reg <= dq_s2_reg;
            end
        end
    end

    // done and refused: a new event wins over the clear
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            done_reg <= 1'b0;
            refused_reg <= 1'b0;
            susp_reg <= 1'b0;
        end else begin
            done_reg <= fin || (done_reg && !start);
            refused_reg <= refuse || (refused_reg && !start);
            if (pd_on) begin
                susp_reg <= 1'b0;
            end else if (state_reg == S_RSMP && op_reg == FESC_OP_SUSPEND &&
                         !poll_again) begin
                susp_reg <= dq_s2_reg[SR_SUSP_BIT];
            end else if (fin && op_reg == FESC_OP_RESUME) begin
                susp_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // software registers and reset recovery
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_reg <= CTRL_RESET;
            blk_addr_reg <= '0;
            prdata_reg <= 32'h0;
            recov_reg <= 4'h0;
        end else begin
            if (wr_acc && hit_ctrl) begin
                ctrl_reg <= pwdata_i[2:0];
            end
            if (wr_acc && hit_addr && !busy) begin
                blk_addr_reg <= pwdata_i[ADDR_W-1:0];
            end
            if (setup_ph) begin
                prdata_reg <= rd_mux;
            end
            if (pd_on) begin
                recov_reg <= 4'(RECOVERY_CYC);
            end else if (recov_reg != 4'h0) begin
                recov_reg <= recov_reg - 4'h1;
            end
        end
    end

    assign reset_powerdown_n_o = !pd_on;
    assign unlock_high_voltage_o = ctrl_reg[CTRL_UNLOCK_BIT];
    assign vpp_en_o = ctrl_reg[CTRL_VPP_BIT];

    // ==========================================================
    // checks
    chk_we_in_select: assert property (@(posedge clk_i)
        disable iff (!arst_n_i)
        !we_n_o |-> !ce_n_o && dq_oe_o && reset_powerdown_n_o)
        else $error("write strobe outside select");
    chk_select_before_we: assert property (@(posedge clk_i)
        disable iff (!arst_n_i)
        $fell(we_n_o) |-> $past(!ce_n_o) && $past(we_n_o))
        else $error("select not low before write strobe");
    chk_confirm_after_setup: assert property (@(posedge clk_i)
        disable iff (!arst_n_i)
        $fell(we_n_o) && op_reg == FESC_OP_ERASE && wr_left_reg == 2'd1
        |-> dq_o == CMD_ERASE_CONFIRM && last_byte_reg == CMD_ERASE_SETUP
            && addr_o == blk_addr_reg)
        else $error("erase confirm not preceded by setup");
    chk_recovery_wait: assert property (@(posedge clk_i)
        disable iff (!arst_n_i)
        $rose(reset_powerdown_n_o) |-> ce_n_o [*6])
        else $error("select during reset recovery");
    chk_poll_toggle: assert property (@(posedge clk_i)
        disable iff (!arst_n_i)
        $fell(oe_n_o) |-> $past(ce_n_o) && $past(oe_n_o))
        else $error("status read without select toggle");
    chk_suspend_poll: assert property (@(posedge clk_i)
        disable iff (!arst_n_i || pd_on)
        state_reg == S_WREC && op_reg == FESC_OP_SUSPEND && !wr_more
        |-> ##1 !oe_n_o)
        else $error("no status read after suspend");
    chk_poll_ready: assert property (@(posedge clk_i)
        disable iff (!arst_n_i)
        $rose(done_reg) && op_reg == FESC_OP_SUSPEND
        |-> sr_reg[SR_READY_BIT])
        else $error("suspend finished before ready");
    chk_array_mode: assert property (@(posedge clk_i)
        disable iff (!arst_n_i)
        $fell(we_n_o) && op_reg == FESC_OP_RD_ARRAY
        |-> dq_o == CMD_READ_ARRAY ##[1:400] !oe_n_o)
        else $error("array read without read array command");
endmodule

/* File: verif/fesc_flash_model.sv */
`timescale 1ns/1ps
module fesc_flash_model #(
    parameter int ERASE_CYC = 80,
    parameter logic [3:0] BOOT_BLK = 4'hF
) (
    input wire logic clk_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic rp_n_i,
    input wire logic unlock_i,
    input wire logic vpp_i,
    input wire logic fail_i,
    input wire logic [17:0] addr_i,
    input wire logic [7:0] ctl_dq_i,
    input wire logic ctl_oe_i,
    output logic [7:0] bus_o
);
    // ==========================================================
    // array, status and sequencer state
    logic [7:0] mem [16];
    logic [7:0] dq_d, last;
    logic [3:0] a_d, blk;
    logic [2:0] err;
    logic wsel, setup, busy, sus_req, susp, rd_sr;
    int cnt;
    wire logic wr = wsel & we_n_i;
    wire logic [7:0] stat = {!busy | susp, susp, err, 3'h0};
    wire logic drive = !ce_n_i & !oe_n_i & rp_n_i;
    wire logic [7:0] rdata = rd_sr ? stat : mem[addr_i[17:14]];
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        {err, wsel, setup, busy, sus_req, susp, rd_sr} = '0;
        last = 8'h00;
    end
    // released bus shows the inverse of its last level
    assign bus_o = ctl_oe_i ? ctl_dq_i : (drive ? rdata : ~last);
    always @(posedge clk_i) last <= bus_o;
    // ==========================================================
    // command front end and erase sequencer
    always @(posedge clk_i or negedge rp_n_i) begin
        if (!rp_n_i) begin
            if (busy) mem[blk] <= 8'h5A;
            {err, wsel, setup, busy, sus_req, susp, rd_sr} <= '0;
        end else begin
            wsel <= !we_n_i & !ce_n_i;
            if (!we_n_i) begin
                dq_d <= ctl_dq_i;
                a_d <= addr_i[17:14];
            end
            if (busy & !vpp_i) begin
                err[0] <= 1'b1;
                {busy, susp, sus_req} <= '0;
            end else if (sus_req & !susp) begin
                susp <= 1'b1;
            end else if (busy & !susp) begin
                cnt <= cnt - 1;
                if (cnt == 0) busy <= 1'b0;
                if (cnt == 0 && fail_i) err[2] <= 1'b1;
                if (cnt == 0 && !fail_i) mem[blk] <= 8'hFF;
            end
            if (wr && setup) begin
                setup <= 1'b0;
                rd_sr <= 1'b1;
                if (dq_d != 8'hD0) err[2:1] <= 2'b11;
                else if (!vpp_i) err <= err | 3'b101;
                else if (a_d == BOOT_BLK && !unlock_i) err[2] <= 1'b1;
                else begin
                    blk <= a_d;
                    busy <= 1'b1;
                    cnt <= ERASE_CYC;
                end
            end else if (wr && busy && !susp) begin
                if (dq_d == 8'hB0) sus_req <= 1'b1;
                rd_sr <= 1'b1;
            end else if (wr && susp) begin
                if (dq_d == 8'hD0) {susp, sus_req} <= '0;
                rd_sr <= (dq_d != 8'hFF);
            end else if (wr) begin
                if (dq_d == 8'h20) setup <= 1'b1;
                if (dq_d == 8'h50) err <= '0;
                rd_sr <= (dq_d != 8'hFF);
            end
        end
    end
endmodule

/* File: verif/tb_flash_erase_suspend_protect.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_flash_erase_suspend_protect;
    import fesc_pkg::*;
    logic clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [7:0] paddr_i = 0, dq_i, dq_o;
    logic [31:0] pwdata_i = 0, prdata_o, rdata, stat;
    logic [17:0] addr_o;
    logic pready_o, pslverr_o, slverr, dq_oe_o, ce_n_o, oe_n_o, we_n_o;
    logic rp_n, unl, vpp, fail_i = 0;
    logic [7:0] mem_exp [16];
    int errors = 0, checks = 0;
    always #25 clk_i = ~clk_i;
    fesc_ctrl dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .addr_o(addr_o), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe_o(dq_oe_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o),
        .we_n_o(we_n_o), .reset_powerdown_n_o(rp_n),
        .unlock_high_voltage_o(unl), .vpp_en_o(vpp));
    fesc_flash_model flash (.clk_i(clk_i), .ce_n_i(ce_n_o), .oe_n_i(oe_n_o),
        .we_n_i(we_n_o), .rp_n_i(rp_n), .unlock_i(unl), .vpp_i(vpp),
        .fail_i(fail_i), .addr_i(addr_o), .ctl_dq_i(dq_o),
        .ctl_oe_i(dq_oe_o), .bus_o(dq_i));
    // ==========================================================
    // expectations and helpers
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [7:0] exp_sr(logic [3:0] b, logic v, logic u,
            logic f);
        if (!v) return 8'hA8;
        if (b == 4'hF && !u) return 8'hA0;
        return f ? 8'hA0 : 8'h80;
    endfunction
    task automatic close_out();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic fail_out();
        errors++;
        close_out();
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 50);
        rdata = prdata_o;
        slverr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 50) fail_out();
    endtask
    task automatic op(input fesc_op_e o);
        int n;
        n = 0;
        apb(1'b1, OFS_CMD, {29'h0, o});
        do begin
            apb(1'b0, OFS_STAT, 32'h0);
            n++;
        end while (rdata[STAT_DONE_BIT] !== 1'b1 && n < 300 &&
            rdata[STAT_REFUSED_BIT] !== 1'b1);
        stat = rdata;
        if (n >= 300) fail_out();
    endtask
    task automatic wait_ready(input logic b);
        int n;
        n = 0;
        op(FESC_OP_RD_STATUS);
        `CHK(stat[SR_READY_BIT], ~b)
        while (stat[SR_READY_BIT] !== 1'b1 && n < 100) begin
            op(FESC_OP_RD_STATUS);
            n++;
        end
        if (n >= 100) fail_out();
    endtask
    initial begin
        #5000000;
        fail_out();
    end
    // ==========================================================
    // main sequence
    initial begin
        logic [15:0] r;
        logic [3:0] b;
        logic v, u, f;
        logic [7:0] e;
        r = 16'd39991;
        foreach (mem_exp[i]) mem_exp[i] = 8'h00;
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK(rdata[2:0], CTRL_RESET)
        apb(1'b0, 8'h10, 32'h0);
        `CHK({slverr, rdata}, 33'h100000000)
        op(FESC_OP_RD_ARRAY);
        `CHK(stat[15:8], 8'h00)
        for (int i = 0; i < 8; i++) begin
            r = lfsr(r);
            b = (i < 2) ? 4'hF : r[3:0];
            v = (i != 2);
            u = (i == 1 || i == 3) | r[4];
            f = (i == 3);
            e = exp_sr(b, v, u, f);
            apb(1'b1, OFS_CTRL, {29'h0, v, u, 1'b0});
            apb(1'b1, OFS_ADDR, {14'h0, b, 14'h0});
            fail_i <= f;
            op(FESC_OP_ERASE);
            wait_ready(e == 8'h80 || f);
            `CHK(stat[7:0], e)
            if (e == 8'h80) mem_exp[b] = 8'hFF;
            op(FESC_OP_CLEAR);
            op(FESC_OP_RD_STATUS);
            `CHK(stat[7:0], 8'h80)
            op(FESC_OP_RD_ARRAY);
            `CHK(stat[15:8], mem_exp[b])
        end
        fail_i <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h4);
        apb(1'b1, OFS_ADDR, 32'h8000);
        op(FESC_OP_ERASE);
        op(FESC_OP_SUSPEND);
        `CHK({stat[STAT_SUSP_BIT], stat[7:6]}, 3'b111)
        apb(1'b1, OFS_ADDR, 32'hC000);
        op(FESC_OP_RD_ARRAY);
        `CHK(stat[15:8], mem_exp[3])
        op(FESC_OP_CLEAR);
        `CHK(stat[STAT_REFUSED_BIT], 1'b1)
        repeat (200) @(posedge clk_i);
        apb(1'b1, OFS_ADDR, 32'h8000);
        op(FESC_OP_RESUME);
        wait_ready(1'b1);
        op(FESC_OP_RD_ARRAY);
        `CHK(stat[15:8], 8'hFF)
        op(FESC_OP_RESUME);
        `CHK(stat[STAT_REFUSED_BIT], 1'b1)
        op(FESC_OP_ERASE);
        apb(1'b1, OFS_CTRL, 32'h0);
        op(FESC_OP_RD_STATUS);
        `CHK(stat[7:0], 8'h88)
        op(FESC_OP_ERASE);
        apb(1'b1, OFS_CTRL, 32'h4);
        op(FESC_OP_ERASE);
        apb(1'b1, OFS_CTRL, 32'h5);
        apb(1'b1, OFS_CTRL, 32'h4);
        op(FESC_OP_RD_STATUS);
        `CHK(stat[STAT_REFUSED_BIT], 1'b1)
        repeat (RECOVERY_CYC) @(posedge clk_i);
        op(FESC_OP_READ);
        `CHK(stat[15:8] !== 8'hFF, 1'b1)
        op(FESC_OP_RD_STATUS);
        `CHK(stat[7:0], 8'h80)
        close_out();
    end
endmodule
